// >>> logic/fiap_pkg.sv
// constants and types shared by the flash trigger front end
package fiap_pkg;
  // register addresses on the special function register bus
  localparam logic [7:0] FIAP_ADDR_TRIG  = 8'ha4;
  localparam logic [7:0] FIAP_ADDR_UEN   = 8'ha5;
  localparam logic [7:0] FIAP_ADDR_AL    = 8'ha6;
  localparam logic [7:0] FIAP_ADDR_AH    = 8'ha7;
  localparam logic [7:0] FIAP_ADDR_TAKEY = 8'hbf;
  // timed access unlock keys
  localparam logic [7:0] FIAP_TA_KEY1 = 8'haa;
  localparam logic [7:0] FIAP_TA_KEY2 = 8'h55;
  // field positions
  localparam int FIAP_TRIG_BIT = 0;
  localparam int FIAP_UEN_APP  = 0;
  localparam int FIAP_UEN_LDR  = 1;
  localparam int FIAP_UEN_CFG  = 2;
  localparam int FIAP_UEN_SEC  = 3;
  localparam int FIAP_UEN_MAP  = 4;
  // reset values
  localparam logic [7:0] FIAP_UEN_RST = 8'h00;
  localparam logic [7:0] FIAP_AL_RST  = 8'h00;
  localparam logic [7:0] FIAP_AH_RST  = 8'h00;
  // secure area window base
  localparam logic [15:0] FIAP_SEC_BASE = 16'hff80;
  // timing
  localparam int FIAP_CLK_NS       = 25;
  localparam int FIAP_TA_WINDOW_NS = 100;
  localparam logic [2:0] FIAP_TA_WINDOW_CYC = 3'(FIAP_TA_WINDOW_NS / FIAP_CLK_NS);
  // flash region targeted by an operation
  typedef enum logic [1:0] {
    FIAP_REG_APP = 2'h0,
    FIAP_REG_LDR = 2'h1,
    FIAP_REG_CFG = 2'h2,
    FIAP_REG_SEC = 2'h3
  } fiap_region_t;
endpackage

// >>> logic/fiap_ta_if.sv
// timed access carrier between the front end and its unlock module
`timescale 1ns/10ps
`default_nettype none
interface fiap_ta_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       used;
  logic       open;
  modport front (output wr, output addr, output wdata, output used, input open);
  modport unlock (input wr, input addr, input wdata, input used, output open);
endinterface
`default_nettype wire

// >>> logic/fiap_ta_unlock.sv
// timed access unlock sequence and protected write window
`timescale 1ns/10ps
`default_nettype none
module fiap_ta_unlock
  import fiap_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  // carrier
  fiap_ta_if.unlock ta
);
  typedef enum logic [2:0] {
    FIAP_TA_IDLE  = 3'b001,
    FIAP_TA_ARMED = 3'b010,
    FIAP_TA_OPEN  = 3'b100
  } fiap_ta_state_t;

  fiap_ta_state_t state;
  logic [2:0]     win_cnt;
  logic           key1_wr;
  logic           key2_wr;

  // key write detection
  assign key1_wr = ta.wr && (ta.addr == FIAP_ADDR_TAKEY) && (ta.wdata == FIAP_TA_KEY1);
  assign key2_wr = ta.wr && (ta.addr == FIAP_ADDR_TAKEY) && (ta.wdata == FIAP_TA_KEY2);
  assign ta.open = (state == FIAP_TA_OPEN);

  // unlock sequencer: first key arms, second key opens a short window
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state   <= FIAP_TA_IDLE;
      win_cnt <= 3'h0;
    end else begin
      unique case (state)
        FIAP_TA_IDLE: begin
          if (key1_wr) begin
            state <= FIAP_TA_ARMED;
          end
        end
        FIAP_TA_ARMED: begin
          if (key2_wr) begin
            state   <= FIAP_TA_OPEN;
            win_cnt <= FIAP_TA_WINDOW_CYC;
          end else if (ta.wr && !key1_wr) begin
            state <= FIAP_TA_IDLE; // wrong sequence drops the arm
          end
        end
        FIAP_TA_OPEN: begin
          win_cnt <= win_cnt - 3'h1;
          if (key1_wr) begin
            state <= FIAP_TA_ARMED;
          end else if (ta.used || win_cnt == 3'h1) begin
            state <= FIAP_TA_IDLE;
          end
        end
      endcase
    end
  end

  // the window never outlives its cycle budget
  ta_window_len_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(ta.open) |-> ##[1:4] !ta.open)
    else $error("timed access window stayed open too long");

  // opening needs the second key as the next write after the first, idle cycles between them allowed
  ta_open_cause_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(ta.open) |-> $past(key2_wr) && $past(state == FIAP_TA_ARMED))
    else $error("timed access window opened without key sequence");
endmodule
`default_nettype wire

// >>> logic/fiap_trigger_ctrl.sv
// flash programming trigger front end on the special function register bus
`timescale 1ns/10ps
`default_nettype none
// How it works
// - writing one to trigger bit 0 starts a flash operation
// - program counter held during the operation, released when it finishes
// - trigger clears itself after the operation; reads always return zero
// - trigger register at A4H, writes accepted only inside timed access window
// - map bit steers 0xff80 to 0xffff to application flash or secure area
// - secure area erase or program only while enable bit 3 set
// - configuration bytes erase or program only while enable bit 2 set
// - loader flash erase or program only while enable bit 1 set
// - application flash erase or program only while enable bit 0 set
// - enable bits at A5H writable only through timed access
// - target address low byte comes from register A6H
// - target address high byte from A7H, no timed access needed
module fiap_trigger_ctrl
  import fiap_pkg::*;
(
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         sys_rst_in,
  // special function register bus
  input  wire logic [7:0]   sfr_addr_in,
  input  wire logic         sfr_wr_in,
  input  wire logic         sfr_rd_in,
  input  wire logic [7:0]   sfr_wdata_in,
  output logic      [7:0]   sfr_rdata_out,
  // operation region from the command logic
  input  wire fiap_region_t op_region_in,
  // cpu side
  input  wire logic [15:0]  cpu_addr_in,
  output logic              cpu_hold_out,
  output logic              secure_area_sel_out,
  // flash engine side
  output logic              flash_start_out,
  output logic [15:0]       flash_addr_out,
  output fiap_region_t      flash_region_out,
  input  wire logic         flash_done_in,
  // status
  output logic              op_done_out,
  output logic              op_blocked_out
);
  typedef enum logic [3:0] {
    FIAP_IDLE  = 4'b0001,
    FIAP_CHECK = 4'b0010,
    FIAP_WAIT  = 4'b0100,
    FIAP_DONE  = 4'b1000
  } fiap_state_t;

  fiap_ta_if ta ();

  fiap_state_t  state;
  logic [7:0]   uen;
  logic [7:0]   addr_lo;
  logic [7:0]   addr_hi;
  logic         trig_accept;
  logic         allowed;
  logic         prot_wr;

  // address decode used by writes and reads alike
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  // region enable lookup
  function automatic logic region_enabled(input fiap_region_t r, input logic [7:0] en);
    logic res;
    res = 1'b0;
    unique case (r)
      FIAP_REG_APP: res = en[FIAP_UEN_APP];
      FIAP_REG_LDR: res = en[FIAP_UEN_LDR];
      FIAP_REG_CFG: res = en[FIAP_UEN_CFG];
      FIAP_REG_SEC: res = en[FIAP_UEN_SEC];
    endcase
    return res;
  endfunction

  // timed access unlock
  fiap_ta_unlock u_ta (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .ta         (ta.unlock)
  );

  // carrier drive and protected write detection
  assign ta.wr    = sfr_wr_in;
  assign ta.addr  = sfr_addr_in;
  assign ta.wdata = sfr_wdata_in;
  assign prot_wr  = sfr_wr_in && ta.open &&
                    (hit(sfr_addr_in, FIAP_ADDR_TRIG) || hit(sfr_addr_in, FIAP_ADDR_UEN));
  assign ta.used  = prot_wr;
  assign trig_accept = sfr_wr_in && hit(sfr_addr_in, FIAP_ADDR_TRIG) && ta.open &&
                       sfr_wdata_in[FIAP_TRIG_BIT] && (state == FIAP_IDLE);
  assign allowed = region_enabled(flash_region_out, uen);

  // update enable register; map bit is not protected, enables are
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      uen <= FIAP_UEN_RST;
    end else if (sfr_wr_in && hit(sfr_addr_in, FIAP_ADDR_UEN)) begin
      uen[FIAP_UEN_MAP] <= sfr_wdata_in[FIAP_UEN_MAP];
      if (ta.open) begin
        uen[FIAP_UEN_SEC:FIAP_UEN_APP] <= sfr_wdata_in[FIAP_UEN_SEC:FIAP_UEN_APP];
      end
    end
  end

  // target address bytes, freely writable
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_lo <= FIAP_AL_RST;
      addr_hi <= FIAP_AH_RST;
    end else if (sfr_wr_in) begin
      if (hit(sfr_addr_in, FIAP_ADDR_AL)) begin
        addr_lo <= sfr_wdata_in;
      end
      if (hit(sfr_addr_in, FIAP_ADDR_AH)) begin
        addr_hi <= sfr_wdata_in;
      end
    end
  end

  // read data register; trigger and unmapped addresses read zero
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      if (hit(sfr_addr_in, FIAP_ADDR_UEN)) begin
        sfr_rdata_out <= {3'h0, uen[FIAP_UEN_MAP:FIAP_UEN_APP]};
      end else if (hit(sfr_addr_in, FIAP_ADDR_AL)) begin
        sfr_rdata_out <= addr_lo;
      end else if (hit(sfr_addr_in, FIAP_ADDR_AH)) begin
        sfr_rdata_out <= addr_hi;
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

  // operation sequencer
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state            <= FIAP_IDLE;
      flash_start_out  <= 1'b0;
      flash_addr_out   <= 16'h0000;
      flash_region_out <= FIAP_REG_APP;
      op_done_out      <= 1'b0;
      op_blocked_out   <= 1'b0;
    end else begin
      flash_start_out <= 1'b0;
      op_done_out     <= 1'b0;
      unique case (state)
        FIAP_IDLE: begin
          if (trig_accept) begin
            state            <= FIAP_CHECK;
            flash_addr_out   <= {addr_hi, addr_lo};
            flash_region_out <= op_region_in;
            op_blocked_out   <= 1'b0;
          end
        end
        FIAP_CHECK: begin
          if (allowed) begin
            flash_start_out <= 1'b1;
            state           <= FIAP_WAIT;
          end else begin
            op_blocked_out <= 1'b1;
            state          <= FIAP_DONE;
          end
        end
        FIAP_WAIT: begin
          if (flash_done_in) begin
            state <= FIAP_DONE;
          end
        end
        FIAP_DONE: begin
          op_done_out <= 1'b1;
          state       <= FIAP_IDLE;
        end
      endcase
    end
  end

  // program counter hold, raised with the accepted trigger
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cpu_hold_out <= 1'b0;
    end else if (trig_accept) begin
      cpu_hold_out <= 1'b1;
    end else if (state == FIAP_DONE) begin
      cpu_hold_out <= 1'b0;
    end
  end

  // secure area window select, one cycle behind the cpu address
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      secure_area_sel_out <= 1'b0;
    end else begin
      secure_area_sel_out <= uen[FIAP_UEN_MAP] && (cpu_addr_in >= FIAP_SEC_BASE);
    end
  end

  trig_holds_pc_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    trig_accept |=> cpu_hold_out && (state == FIAP_CHECK))
    else $error("trigger did not hold the program counter");

  hold_release_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (state == FIAP_DONE) |=> !cpu_hold_out && op_done_out)
    else $error("program counter not released after operation");

  trig_reads_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    sfr_rd_in && hit(sfr_addr_in, FIAP_ADDR_TRIG) |=> sfr_rdata_out == 8'h00)
    else $error("trigger register read nonzero");

  trig_needs_ta_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    sfr_wr_in && hit(sfr_addr_in, FIAP_ADDR_TRIG) && !ta.open && (state == FIAP_IDLE)
    && !cpu_hold_out |=> !cpu_hold_out)
    else $error("trigger accepted without timed access");

  uen_protect_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    sfr_wr_in && hit(sfr_addr_in, FIAP_ADDR_UEN) && !ta.open |=> $stable(uen[3:0]))
    else $error("update enables changed without timed access");

  start_enabled_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    flash_start_out |-> region_enabled(flash_region_out, uen))
    else $error("flash action started on a disabled region");

  blocked_release_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (state == FIAP_CHECK) && !allowed |=> !flash_start_out ##1 !cpu_hold_out)
    else $error("blocked operation mishandled");

  target_addr_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    trig_accept |=> flash_addr_out == {$past(addr_hi), $past(addr_lo)})
    else $error("target address not taken from address registers");

  secure_map_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 secure_area_sel_out == ($past(uen[FIAP_UEN_MAP]) && ($past(cpu_addr_in) >= FIAP_SEC_BASE)))
    else $error("secure area select wrong");

  op_done_c: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    flash_start_out ##[1:50] op_done_out);
  op_blocked_c: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    (state == FIAP_CHECK) && !allowed);
  secure_sel_c: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    secure_area_sel_out);
endmodule
`default_nettype wire

// >>> test/fiap_flash_model.sv
// behavioural flash engine that answers each start after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module fiap_flash_model (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  // engine handshake
  input  wire logic       start_in,
  input  wire logic [3:0] delay_in,
  output logic            done_out
);
  logic       busy;
  logic [3:0] cnt;
  // count down from start, then pulse done for one cycle
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy     <= 1'b0;
      cnt      <= 4'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        busy <= 1'b1;
        cnt  <= delay_in;
      end else if (busy) begin
        if (cnt <= 4'h1) begin
          busy     <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the flash trigger front end
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import fiap_pkg::*;
;
  logic         clock_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic [7:0]   sfr_addr_in = 8'h00;
  logic         sfr_wr_in = 1'b0;
  logic         sfr_rd_in = 1'b0;
  logic [7:0]   sfr_wdata_in = 8'h00;
  logic [7:0]   sfr_rdata_out;
  fiap_region_t op_region_in = FIAP_REG_APP;
  logic [15:0]  cpu_addr_in = 16'h0000;
  logic         cpu_hold_out, secure_area_sel_out, flash_start_out;
  logic [15:0]  flash_addr_out;
  fiap_region_t flash_region_out;
  logic         flash_done_in, op_done_out, op_blocked_out;
  logic [3:0]   delay = 4'h1;
  int           mismatches = 0;
  int           n_compared = 0;
  int           n_start = 0;
  logic         saw_hold = 1'b0;

  // 40 MHz clock
  always #12.5 clock_in = ~clock_in;

  fiap_trigger_ctrl fiap_trigger_ctrl_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .op_region_in(op_region_in),
    .cpu_addr_in(cpu_addr_in), .cpu_hold_out(cpu_hold_out),
    .secure_area_sel_out(secure_area_sel_out), .flash_start_out(flash_start_out),
    .flash_addr_out(flash_addr_out), .flash_region_out(flash_region_out),
    .flash_done_in(flash_done_in), .op_done_out(op_done_out),
    .op_blocked_out(op_blocked_out));

  fiap_flash_model fiap_flash_model_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .start_in(flash_start_out),
    .delay_in(delay), .done_out(flash_done_in));

  // watch engine starts and program counter hold
  always @(posedge clock_in) begin
    if (flash_start_out === 1'b1) n_start++;
    if (cpu_hold_out === 1'b1) saw_hold = 1'b1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one-cycle write strobe launched off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge clock_in);
    sfr_wr_in = 1'b0;
  endtask

  // read strobe, data checked a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge clock_in);
    sfr_rd_in = 1'b0;
    chk(16'(sfr_rdata_out), 16'(exp));
  endtask

  task automatic unlock();
    wr(FIAP_ADDR_TAKEY, FIAP_TA_KEY1);
    wr(FIAP_ADDR_TAKEY, FIAP_TA_KEY2);
  endtask

  // protected trigger, then wait for the end of the operation
  task automatic run_op(input logic [1:0] r, input logic ok);
    int i;
    op_region_in = fiap_region_t'(r);
    delay = 4'(3 * r + 1);
    n_start = 0;
    saw_hold = 1'b0;
    unlock();
    // the bench raises no interrupts, so none need masking before the trigger
    wr(FIAP_ADDR_TRIG, 8'h01);
    for (i = 0; i < 40 && op_done_out !== 1'b1; i++) @(negedge clock_in);
    chk(16'(op_done_out), 16'h0001);
    chk(16'(saw_hold), 16'h0001);
    chk(16'(cpu_hold_out), 16'h0000);
    chk(16'(n_start), 16'(ok));
    chk(16'(op_blocked_out), 16'(!ok));
    chk(flash_addr_out, 16'h1234);
    chk(16'(flash_region_out), 16'(r));
  endtask

  initial begin
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    rd(FIAP_ADDR_TRIG, 8'h00);
    rd(FIAP_ADDR_UEN, FIAP_UEN_RST);
    rd(FIAP_ADDR_AL, FIAP_AL_RST);
    rd(FIAP_ADDR_AH, FIAP_AH_RST);
    rd(8'h10, 8'h00);
    wr(FIAP_ADDR_AL, 8'h34);
    wr(FIAP_ADDR_AH, 8'h12);
    rd(FIAP_ADDR_AL, 8'h34);
    rd(FIAP_ADDR_AH, 8'h12);
    // unprotected write reaches only the map bit
    wr(FIAP_ADDR_UEN, 8'h1f);
    rd(FIAP_ADDR_UEN, 8'h10);
    // a foreign write between the keys drops the arm
    wr(FIAP_ADDR_TAKEY, FIAP_TA_KEY1);
    wr(FIAP_ADDR_AL, 8'h34);
    wr(FIAP_ADDR_TAKEY, FIAP_TA_KEY2);
    wr(FIAP_ADDR_UEN, 8'h1f);
    rd(FIAP_ADDR_UEN, 8'h10);
    unlock();
    wr(FIAP_ADDR_UEN, 8'h1f);
    rd(FIAP_ADDR_UEN, 8'h1f);
    // trigger without unlock is ignored
    n_start = 0;
    saw_hold = 1'b0;
    wr(FIAP_ADDR_TRIG, 8'h01);
    repeat (10) @(negedge clock_in);
    chk(16'(n_start), 16'h0000);
    chk(16'(saw_hold), 16'h0000);
    // every region allowed, then every region blocked
    for (int r = 0; r < 4; r++) run_op(2'(r), 1'b1);
    rd(FIAP_ADDR_TRIG, 8'h00);
    unlock();
    wr(FIAP_ADDR_UEN, 8'h10);
    for (int r = 0; r < 4; r++) run_op(2'(r), 1'b0);
    // window runs out before the protected write
    unlock();
    repeat (6) @(negedge clock_in);
    wr(FIAP_ADDR_UEN, 8'h1f);
    rd(FIAP_ADDR_UEN, 8'h10);
    // secure window decode
    cpu_addr_in = 16'hff80;
    repeat (2) @(negedge clock_in);
    chk(16'(secure_area_sel_out), 16'h0001);
    cpu_addr_in = 16'hff7f;
    repeat (2) @(negedge clock_in);
    chk(16'(secure_area_sel_out), 16'h0000);
    wr(FIAP_ADDR_UEN, 8'h00);
    cpu_addr_in = 16'hffff;
    repeat (2) @(negedge clock_in);
    chk(16'(secure_area_sel_out), 16'h0000);
    // mid-run reset brings the address registers back to their reset values
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'b0;
    rd(FIAP_ADDR_AL, FIAP_AL_RST);
    rd(FIAP_ADDR_AH, FIAP_AH_RST);
    conclude();
  end

  // hang guard well beyond the expected run
  initial begin
    #(25 * 5000);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
